// ### hdl/tctm_timer.sv
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module tctm_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input tctm_pkg::tctm_trig_t trig_in,
   input wire logic sleep_in,
   output tctm_pkg::tctm_flags_t flags_out,
   output logic cc_irq_src,
   output logic [tctm_pkg::CNT_W-1:0] count_out
);
   import tctm_pkg::*;

   tctm_state_t s_q;
   tctm_state_t s_d;
   tctm_trig_t trig_edge;
   tctm_trig_t sw_cmd;
   logic wr_cmd;
   logic wr_count;
   logic addr_ok;
   logic active;
   logic updn;
   logic tick;
   logic step;
   logic load_ev;
   logic start_ev;
   logic stop_ev;
   logic capt_ev;
   logic dn;
   logic [CNT_W-1:0] nxt;

   // ==========================================================
   // Trigger edges and software commands
   // Edges look only at the second synchroniser stage and its delayed copy
   assign trig_edge = s_q.trig_s2 & ~s_q.trig_prev; // see R23
   assign wr_cmd = (s_q.bus == BUS_WRITE) && (s_q.addr == OFS_CMD);
   assign wr_count = (s_q.bus == BUS_WRITE) && (s_q.addr == OFS_COUNT);
   assign sw_cmd = wr_cmd ? '{capture: hwdata[CMD_CAPTURE_BIT], reload: hwdata[CMD_RELOAD_BIT],
                             stop: hwdata[CMD_STOP_BIT], start: hwdata[CMD_START_BIT],
                             count: 1'b0} : '0;
   // Bus is ignored while the sleep level is present
   assign addr_ok = hsel && hready && htrans[1] && !s_q.sleep_s2; // see R17

   // Only timer and capture modes run here; other encodings leave the counter idle
   assign active = s_q.enable && ((s_q.ctrl.mode == MODE_TIMER) ||
                                  (s_q.ctrl.mode == MODE_CAPTURE)); // see R1
   assign updn = s_q.ctrl.dir[1];
   assign load_ev = active && (trig_edge.reload || sw_cmd.reload);
   assign start_ev = active && (trig_edge.start || sw_cmd.start);
   assign stop_ev = active && (trig_edge.stop || sw_cmd.stop);
   assign capt_ev = active && (s_q.ctrl.mode == MODE_CAPTURE) &&
                    (trig_edge.capture || sw_cmd.capture);

   // ==========================================================
   // Bus answer signals and the flag, interrupt and count outputs
   assign hreadyout = (s_q.bus != BUS_READ_WAIT);
   assign hrdata = s_q.rdata;
   assign hresp = 1'b0;
   assign flags_out = s_q.flags;
   assign cc_irq_src = s_q.flags.cc; // see R12
   assign count_out = s_q.count;

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.flags = '0;
      tick = 1'b0;
      step = 1'b0;
      dn = s_q.down;
      nxt = s_q.count;

      // Two-stage synchronisers for every pin input
      s_d.trig_s1 = trig_in; // see R23
      s_d.trig_s2 = s_q.trig_s1;
      s_d.trig_prev = s_q.trig_s2;
      s_d.sleep_s1 = sleep_in;
      s_d.sleep_s2 = s_q.sleep_s1;

      // Bus phase tracking, one wait state on reads
      case (s_q.bus)
         BUS_READ_WAIT: begin
            s_d.bus = BUS_READ_DONE;
            case (s_q.addr)
               OFS_CTRL: s_d.rdata = s_q.ctrl & CTRL_WMASK;
               OFS_CMD: s_d.rdata = {31'h00000000, s_q.enable};
               OFS_COUNT: s_d.rdata = {16'h0000, s_q.count};
               OFS_CC: s_d.rdata = {16'h0000, s_q.cc};
               OFS_CC_BUF: s_d.rdata = {16'h0000, s_q.cc_buf};
               OFS_PERIOD: s_d.rdata = {16'h0000, s_q.period};
               OFS_CAPT: s_d.rdata = {16'h0000, s_q.capt};
               OFS_CAPT_BUF: s_d.rdata = {16'h0000, s_q.capt_buf};
               OFS_STATUS: s_d.rdata = {29'h00000000, s_q.enable, s_q.down, s_q.running};
               default: s_d.rdata = 32'h00000000;
            endcase
         end
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (addr_ok) begin
               s_d.addr = haddr[ADDR_W-1:0];
               s_d.bus = hwrite ? BUS_WRITE : BUS_READ_WAIT;
            end else begin
               s_d.bus = BUS_IDLE;
            end
            if (s_q.sleep_s2) begin
               s_d.rdata = 32'h00000000;
            end
         end
         default: s_d.bus = BUS_IDLE;
      endcase

      // Enable bit of the command register
      if (wr_cmd) begin
         s_d.enable = hwdata[CMD_ENABLE_BIT];
      end

      // Prescaler makes the counter clock enable
      if (s_q.enable) begin
         if (s_q.presc_cnt >= s_q.ctrl.presc) begin
            s_d.presc_cnt = 8'h00;
            tick = 1'b1;
         end else begin
            s_d.presc_cnt = s_q.presc_cnt + 8'h01;
         end
      end else begin
         s_d.presc_cnt = 8'h00;
      end

      // A count event is the synchronised count level on a counter tick
      step = active && s_q.running && tick && s_q.trig_s2.count && !load_ev; // see R2 R25

      // Counting per direction setting
      case (s_q.ctrl.dir)
         DIR_UP: begin
            nxt = (s_q.count >= s_q.period) ? '0 : s_q.count + CNT_ONE; // see R8 R14
         end
         DIR_DOWN: begin
            nxt = (s_q.count == '0) ? s_q.period : s_q.count - CNT_ONE; // see R9 R14
         end
         DIR_UPDN_ZERO, DIR_UPDN_BOTH: begin
            // Turn at the end values instead of reloading
            if (dn && (s_q.count == '0)) begin
               dn = 1'b0; // see R10
            end
            if (!dn && (s_q.count >= s_q.period)) begin
               dn = 1'b1; // see R10
            end
            nxt = dn ? s_q.count - CNT_ONE : s_q.count + CNT_ONE; // see R15
         end
         default: nxt = s_q.count;
      endcase

      if (step) begin
         s_d.count = nxt; // see R2
         if (!updn) begin
            s_d.down = s_q.ctrl.dir[0];
            s_d.flags.ceil = !s_q.ctrl.dir[0] && (nxt == s_q.period); // see R21 R20
            s_d.flags.floor = s_q.ctrl.dir[0] && (nxt == '0); // see R21 R20
            s_d.flags.tc = s_d.flags.ceil || s_d.flags.floor; // see R4 R5
         end else begin
            s_d.down = (nxt == s_q.period) ? 1'b1 : ((nxt == '0) ? 1'b0 : dn); // see R10
            s_d.flags.ceil = !dn && (nxt == s_q.period); // see R21
            s_d.flags.floor = dn && (nxt == '0); // see R21
            // Setting 10 flags zero only, setting 11 both ends
            s_d.flags.tc = (nxt == '0) ||
                           (s_q.ctrl.dir[0] && !dn && (nxt == s_q.period)); // see R6 R7
         end
         // Compare match and optional swap with the buffer
         if (nxt == s_q.cc) begin
            s_d.flags.cc = 1'b1; // see R11
            if (s_q.ctrl.swap_en) begin
               s_d.cc = s_q.cc_buf; // see R11
               s_d.cc_buf = s_q.cc;
            end
         end
      end

      // Reload initialises the count and starts counting
      if (load_ev) begin
         s_d.count = updn ? CNT_ONE : (s_q.ctrl.dir[0] ? s_q.period : '0); // see R22
         s_d.down = s_q.ctrl.dir[0] && !updn;
         s_d.running = 1'b1;
      end

      // Start and stop; stop wins when both arrive together
      if (start_ev) begin
         s_d.running = 1'b1;
      end
      if (stop_ev) begin
         s_d.running = 1'b0;
      end

      // One-shot halts after its first terminal count
      if (s_d.flags.tc && s_q.ctrl.one_shot) begin
         s_d.running = 1'b0; // see R24 R13
      end

      // Capture copies count, and the old capture into its buffer
      if (capt_ev) begin
         s_d.capt = s_q.count; // see R3
         s_d.capt_buf = s_q.capt;
         s_d.flags.cc = 1'b1;
      end

      // A disabled counter stops and holds its count
      if (!s_q.enable) begin
         s_d.running = 1'b0; // see R25
      end

      // Register writes take effect last so software wins
      if (s_q.bus == BUS_WRITE) begin
         case (s_q.addr)
            OFS_CTRL: s_d.ctrl = tctm_ctrl_t'(hwdata & CTRL_WMASK); // see R1
            OFS_CC: s_d.cc = hwdata[CNT_W-1:0];
            OFS_CC_BUF: s_d.cc_buf = hwdata[CNT_W-1:0];
            OFS_PERIOD: s_d.period = hwdata[CNT_W-1:0];
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end
      if (wr_count) begin
         s_d.count = hwdata[CNT_W-1:0]; // see R16
      end
   end

   // ==========================================================
   // State register; power loss arrives as reset, a stopped clock holds all
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0; // see R19
         s_q.ctrl <= RST_CTRL;
         s_q.period <= RST_PERIOD;
      end else begin
         s_q <= s_d; // see R18
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence up_to_top;
      step && (s_q.ctrl.dir == DIR_UP) && (s_q.count < s_q.period) &&
      (s_q.count + CNT_ONE == s_q.period) && !wr_count;
   endsequence

   sequence updn_to_top;
      step && updn && !s_q.down && (s_q.count < s_q.period) &&
      (s_q.count + CNT_ONE == s_q.period) && !wr_count;
   endsequence

   sequence down_to_zero;
      step && (s_q.ctrl.dir == DIR_DOWN) && (s_q.count == CNT_ONE) && !wr_count;
   endsequence

   a_count_hold: assert property (!step && !load_ev && !wr_count |=> $stable(s_q.count))
      else $error("count changed without a count event"); // see R2 R25

   a_up_top_tc: assert property (up_to_top |=> s_q.flags.tc && s_q.flags.ceil)
      else $error("up count reaching period gave no terminal count"); // see R4 R21

   a_up_wrap_zero: assert property (up_to_top ##1 (step && !wr_count) |=> s_q.count == '0)
      else $error("up count did not wrap to zero"); // see R8

   a_down_zero_tc: assert property (down_to_zero |=> s_q.flags.tc && s_q.flags.floor)
      else $error("down count reaching zero gave no terminal count"); // see R5 R21

   a_down_reload: assert property (down_to_zero ##1 (step && !wr_count && !load_ev)
         |=> s_q.count == $past(s_q.period))
      else $error("down count did not reload period"); // see R9

   a_updn_turn: assert property (updn_to_top |=> s_q.down && s_q.flags.ceil &&
         (s_q.flags.tc == (s_q.ctrl.dir == DIR_UPDN_BOTH)))
      else $error("up/down turn or terminal count wrong at period"); // see R6 R7 R10

   a_updn_reload_one: assert property (load_ev && updn && !wr_count |=> s_q.count == CNT_ONE)
      else $error("up/down reload did not load one"); // see R22

   a_wrap_pulse: assert property ((s_q.flags.ceil || s_q.flags.floor) && (s_q.period > CNT_ONE)
         |=> !s_q.flags.ceil && !s_q.flags.floor)
      else $error("wrap flag longer than one cycle"); // see R20

   a_cmp_swap: assert property (step && (nxt == s_q.cc) && s_q.ctrl.swap_en &&
         (s_q.bus != BUS_WRITE) |=> s_q.flags.cc && (s_q.cc == $past(s_q.cc_buf)) &&
         (s_q.cc_buf == $past(s_q.cc)))
      else $error("compare match or swap missing"); // see R11

   a_oneshot_halt: assert property (s_q.flags.tc && $past(s_q.ctrl.one_shot) |-> !s_q.running)
      else $error("one-shot kept running after terminal count"); // see R24

   a_disabled_quiet: assert property (!s_q.enable |=> !s_q.flags.tc && !s_q.flags.cc)
      else $error("disabled counter raised an event"); // see R25

   a_capture_copy: assert property (capt_ev && !step |=> s_q.flags.cc &&
         (s_q.capt == $past(s_q.count)) && (s_q.capt_buf == $past(s_q.capt)))
      else $error("capture did not copy count"); // see R3

   a_sleep_ignore: assert property (s_q.sleep_s2 |=> s_q.bus == BUS_IDLE)
      else $error("bus access taken during sleep"); // see R17

endmodule

// ### hdl/tctm_pkg.sv
// Notes on behaviour
// R1: Control field [26:24] picks the mode: timer, capture, quadrature, three pulse modes. Only timer and capture count here; the others leave the counter idle.
// R2: Timer mode moves count by exactly one per counter tick with a count event.
// R3: Capture mode counts like timer and copies count into capture on capture events.
// R4: Direction 00 counts up; terminal_count when count equals period.
// R5: Direction 01 counts down from period; terminal_count when count reaches zero.
// R6: Direction 10 counts up to period then down; terminal_count only at zero.
// R7: Direction 11 counts like 10 but terminal_count at zero and at period.
// R8: Counting up, the count after reaching period loads zero.
// R9: Counting down, the count after reaching zero loads the period value.
// R10: Up/down settings never reload at end values; they reverse direction instead.
// R11: compare_match_condition when count equals compare; optional compare/buffer swap then.
// R12: compare_match_condition is offered as an interrupt request source.
// R13: Continuous and one-shot run settings work in every counting direction.
// R14: Up or down counting takes period plus one ticks per period.
// R15: Up/down counting takes twice period ticks, from one to period and back.
// R16: Software should not write the count register while the counter runs.
// R17: In sleep the counter keeps running while bus accesses are ignored.
// R18: In deep sleep the clock stops but configuration registers keep contents.
// R19: Hibernate and stop lose power; registers return to reset values.
// R20: ceiling_wrap_flag and floor_wrap_flag are one clock cycle pulses.
// R21: Ceiling flag on reaching period counting up; floor flag on zero counting down.
// R22: Up/down settings load one into the count on a reload event.
// R23: Every trigger input is synchronised to the clock before use.
// R24: One-shot stops after the first terminal_count until restarted.
// R25: A disabled counter holds its count and raises no events.
package tctm_pkg;

   // ==========================================================
   // Widths and register offsets
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CC = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CC_BUF = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CAPT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CAPT_BUF = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

   // ==========================================================
   // Field positions, masks and reset values
   localparam int unsigned CMD_ENABLE_BIT = 0;
   localparam int unsigned CMD_START_BIT = 1;
   localparam int unsigned CMD_STOP_BIT = 2;
   localparam int unsigned CMD_RELOAD_BIT = 3;
   localparam int unsigned CMD_CAPTURE_BIT = 4;
   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_DOWN_BIT = 1;
   localparam int unsigned STAT_EN_BIT = 2;
   localparam logic [31:0] CTRL_WMASK = 32'h0707ff01;
   localparam logic [31:0] RST_CTRL = 32'h00000000;
   localparam logic [CNT_W-1:0] RST_PERIOD = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // ==========================================================
   // Modes, directions and bus states
   typedef enum logic [2:0] {
      MODE_TIMER = 3'b000,
      MODE_CAPTURE = 3'b010,
      MODE_QUADRATURE = 3'b011,
      MODE_PULSE = 3'b100,
      MODE_DEAD_TIME_PULSE = 3'b101,
      MODE_PSEUDO_RANDOM_PULSE = 3'b110
   } tctm_mode_t;

   typedef enum logic [1:0] {
      DIR_UP = 2'b00,
      DIR_DOWN = 2'b01,
      DIR_UPDN_ZERO = 2'b10,
      DIR_UPDN_BOTH = 2'b11
   } tctm_dir_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ_WAIT = 2'b10,
      BUS_READ_DONE = 2'b11
   } tctm_bus_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [4:0] rsv_hi;
      logic [2:0] mode;
      logic [4:0] rsv_mid;
      logic one_shot;
      logic [1:0] dir;
      logic [7:0] presc;
      logic [6:0] rsv_lo;
      logic swap_en;
   } tctm_ctrl_t;

   typedef struct packed {
      logic capture;
      logic reload;
      logic stop;
      logic start;
      logic count;
   } tctm_trig_t;

   typedef struct packed {
      logic tc;
      logic cc;
      logic ceil;
      logic floor;
   } tctm_flags_t;

   typedef struct packed {
      tctm_bus_t bus;
      logic [ADDR_W-1:0] addr;
      logic [31:0] rdata;
      tctm_ctrl_t ctrl;
      logic enable;
      logic running;
      logic down;
      logic [7:0] presc_cnt;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] cc;
      logic [CNT_W-1:0] cc_buf;
      logic [CNT_W-1:0] capt;
      logic [CNT_W-1:0] capt_buf;
      tctm_trig_t trig_s1;
      tctm_trig_t trig_s2;
      tctm_trig_t trig_prev;
      logic sleep_s1;
      logic sleep_s2;
      tctm_flags_t flags;
   } tctm_state_t;

endpackage

// ### tb/tb_tctm_timer.sv
`timescale 1ns/1ps
module tb_tctm_timer;
   import tctm_pkg::*;
   // ==========================================================
   // Row layout: mode, direction, prescale, period, compare
   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] dir;
      logic [7:0] presc;
      logic [15:0] per;
      logic [15:0] cmp;
   } tctm_row_t;
   localparam tctm_row_t rows [0:4] = '{
      '{3'h0, 2'h0, 8'h00, 16'h0006, 16'h0003},
      '{3'h2, 2'h1, 8'h00, 16'h0006, 16'h00ff},
      '{3'h0, 2'h2, 8'h01, 16'h0005, 16'h0002},
      '{3'h0, 2'h3, 8'h00, 16'h0005, 16'h0005},
      '{3'h0, 2'h0, 8'h02, 16'h0004, 16'h0000}};
   // ==========================================================
   // Stimulus and observed signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   tctm_trig_t trig_in = 5'h01;
   logic sleep_in = 1'b0;
   logic hreadyout;
   logic hresp;
   logic cc_irq_src;
   logic [31:0] hrdata;
   tctm_flags_t flags_out;
   logic [CNT_W-1:0] count_out;
   logic [31:0] rd;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   // Clock generator, 4 ns period
   always #2 hclk = ~hclk;
   // Device under test, single slave so hready is its own hreadyout
   tctm_timer tctm_timer_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .trig_in(trig_in),
      .sleep_in(sleep_in), .flags_out(flags_out), .cc_irq_src(cc_irq_src),
      .count_out(count_out));
   // ==========================================================
   // Reporting
   task automatic conclude();
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   // Hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   // ==========================================================
   // Bus master: hready is sampled via the stable level before the edge
   task automatic rdy();
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
      rd = hrdata;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Enable first; a reload in the same write as enable is not seen
   task automatic go();
      wr(OFS_CMD, 32'h1);
      wr(OFS_CMD, 32'h9);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   // ==========================================================
   // One row: start, find the end value, then walk every step
   task automatic run_row(input tctm_row_t r);
      logic [15:0] c;
      logic up;
      logic tc;
      int k;
      c = (r.dir == 2'h1) ? 16'h0 : r.per;
      up = (r.dir != 2'h1);
      k = 0;
      wr(OFS_CMD, 32'h0);
      wr(OFS_CTRL, {5'h0, r.mode, 6'h0, r.dir, r.presc, 8'h00});
      wr(OFS_PERIOD, {16'h0, r.per});
      wr(OFS_CC, {16'h0, r.cmp});
      go();
      do begin
         @(negedge hclk);
         k++;
      end while (count_out !== c && k < 200);
      for (int s = 0; s < 3 * r.per; s++) begin
         tc = (!up && c == 16'h0) || (up && c == r.per && r.dir != 2'h2);
         chk("step", {11'h0, c, tc, c == r.cmp, up && c == r.per, !up && c == 16'h0,
             c == r.cmp}, {11'h0, count_out, flags_out, cc_irq_src});
         for (int h = 0; h < r.presc; h++) begin
            @(negedge hclk);
            chk("hold", {11'h0, c, 5'h0}, {11'h0, count_out, flags_out, cc_irq_src});
         end
         if (up && c == r.per) begin
            up = !r.dir[1];
            c = r.dir[1] ? r.per - 16'h1 : 16'h0;
         end else if (!up && c == 16'h0) begin
            up = r.dir[1];
            c = r.dir[1] ? 16'h1 : r.per;
         end else begin
            c = up ? c + 16'h1 : c - 16'h1;
         end
         @(negedge hclk);
      end
      @(posedge hclk);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      int k;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFS_CTRL, RST_CTRL);
      rdc(OFS_PERIOD, {16'h0, RST_PERIOD});
      rdc(OFS_COUNT, 32'h0);
      wr(8'h24, 32'hffffffff);
      rdc(8'h24, 32'h0);
      wr(OFS_CAPT, 32'h00001111);
      rdc(OFS_CAPT, 32'h0);
      // Ordinary cases from the table
      for (int i = 0; i < 5; i++) begin
         run_row(rows[i]);
      end
      // Software capture with the count pin idle
      trig_in.count <= 1'b0;
      wr(OFS_CTRL, 32'h02000000);
      go();
      wr(OFS_COUNT, 32'h1234);
      wr(OFS_CMD, 32'h11);
      rdc(OFS_CAPT, 32'h1234);
      wr(OFS_COUNT, 32'h0055);
      wr(OFS_CMD, 32'h11);
      rdc(OFS_CAPT, 32'h0055);
      rdc(OFS_CAPT_BUF, 32'h1234);
      // Reload through the synchronised pin in up/down counting
      wr(OFS_CTRL, 32'h00020000);
      wr(OFS_COUNT, 32'h0020);
      trig_in.reload <= 1'b1;
      repeat (3) @(posedge hclk);
      trig_in.reload <= 1'b0;
      repeat (3) @(posedge hclk);
      rdc(OFS_COUNT, 32'h1);
      // Disabled counter ignores count events
      wr(OFS_CMD, 32'h0);
      trig_in.count <= 1'b1;
      repeat (8) begin
         @(negedge hclk);
         chk("off", 32'h20, {11'h0, count_out, flags_out, cc_irq_src});
      end
      @(posedge hclk);
      // One-shot stops after its first terminal count
      wr(OFS_CTRL, 32'h00040000);
      wr(OFS_PERIOD, 32'h3);
      go();
      repeat (20) @(posedge hclk);
      rdc(OFS_STATUS, 32'h4);
      // Compare and buffer swap on a match, slow prescale
      wr(OFS_CMD, 32'h0);
      wr(OFS_CTRL, 32'h00000701);
      wr(OFS_PERIOD, 32'h6);
      wr(OFS_CC, 32'h2);
      wr(OFS_CC_BUF, 32'h4);
      go();
      k = 0;
      do begin
         @(negedge hclk);
         k++;
      end while (flags_out.cc !== 1'b1 && k < 100);
      @(posedge hclk);
      wr(OFS_CMD, 32'h0);
      rdc(OFS_CC, 32'h4);
      rdc(OFS_CC_BUF, 32'h2);
      // Quadrature and pulse encodings leave the count alone
      for (int m = 3; m < 7; m++) begin
         wr(OFS_CTRL, {5'h0, m[2:0], 24'h0});
         wr(OFS_COUNT, 32'h7);
         go();
         repeat (6) @(posedge hclk);
         rdc(OFS_COUNT, 32'h7);
      end
      // Sleep: bus refused, counter keeps running
      wr(OFS_CTRL, 32'h0);
      wr(OFS_PERIOD, 32'h100);
      go();
      sleep_in <= 1'b1;
      repeat (3) @(posedge hclk);
      rdc(OFS_COUNT, 32'h0);
      wr(OFS_PERIOD, 32'h5);
      sleep_in <= 1'b0;
      repeat (6) @(posedge hclk);
      rdc(OFS_PERIOD, 32'h100);
      chk("run in sleep", 32'h1, {31'h0, count_out > 16'h0008});
      conclude();
   end
endmodule
